// ---- core/rsq_pkg.sv ----
// Constants for the reset sequencer and reset-cause flags.
// Assumes a 100 MHz device clock and a 32-bit AXI4-Lite register bus.
package rsq_pkg;
  // Register byte offsets
  localparam logic [7:0] RSQ_OFS_FLAGS = 8'h00; // Power-control reset flags
  localparam logic [7:0] RSQ_OFS_STAT = 8'h04; // Timeout / power-down / core state
  localparam logic [7:0] RSQ_OFS_CFG = 8'h08; // Configuration bits
  // Flag register field positions
  localparam int RSQ_B_STACK_OVERFLOW_FLAG = 7;
  localparam int RSQ_B_STACK_UNDERFLOW_FLAG = 6;
  localparam int RSQ_B_PIN = 3;
  localparam int RSQ_B_INSTR = 2;
  localparam int RSQ_B_POR = 1;
  localparam int RSQ_B_BOR = 0;
  localparam logic [7:0] RSQ_FLAGS_WMASK = 8'hCF; // Bits 5:4 unimplemented
  localparam logic [7:0] RSQ_FLAGS_RST = 8'h0C; // Value after power-on
  // Configuration field positions and reset value
  localparam int RSQ_C_POWERUP_TIMER_N = 0;
  localparam int RSQ_C_PIN_EN = 1;
  localparam int RSQ_C_LVP = 2;
  localparam int RSQ_C_STACK_ERROR_RESET_ENABLE = 3;
  localparam logic [3:0] RSQ_CFG_RST = 4'h2;
  // Program counter vectors
  localparam int RSQ_PC_W = 16;
  localparam logic [15:0] RSQ_RESET_VEC = 16'h0000;
  localparam logic [15:0] RSQ_INT_VEC = 16'h0004;
  // Bus answers
  localparam logic [1:0] RSQ_RESP_OK = 2'h0;
  localparam logic [1:0] RSQ_RESP_SLVERR = 2'h2;
  // Power-up timer figure and derived cycle count
  localparam int RSQ_POWERUP_TIMER_TIME_US = 64000;
  localparam int RSQ_CLK_MHZ = 100;
  localparam int RSQ_POWERUP_TIMER_CYCLES = RSQ_POWERUP_TIMER_TIME_US * RSQ_CLK_MHZ;
  // Sequencer states
  typedef enum logic [1:0] {
    RSQ_ST_HOLD,
    RSQ_ST_POWERUP_TIMER,
    RSQ_ST_START,
    RSQ_ST_RUN
  } rsq_state_t;
endpackage : rsq_pkg

// ---- core/rsq_reset_sequencer.sv ----
// Reset sequencer with reset-cause flags and an AXI4-Lite register slave.
// Assumes detector and pin inputs are asynchronous; core event pulses are on sys_clk_in.
`timescale 1ns/1ps
`default_nettype none

module rsq_reset_sequencer import rsq_pkg::*; #(
  parameter int unsigned POWERUP_TIMER_CYCLES = RSQ_POWERUP_TIMER_CYCLES, // Power-up timer length
  parameter int CNT_W = 23 // Power-up counter width
) (
  input wire logic sys_clk_in, // Device clock
  input wire logic rst_in, // Async reset, active high
  input wire logic por_det_in, // Power-on detector active (async)
  input wire logic bor_det_in, // Brown-out detector active (async)
  input wire logic ext_reset_pin_n_in, // External reset pin, low resets (async)
  input wire logic prog_exit_in, // Programming mode exit pulse
  input wire logic ost_required_in, // Oscillator needs start-up timer
  input wire logic ost_done_in, // Oscillator start-up timer done
  input wire logic asleep_in, // Core is in sleep
  input wire logic wdt_event_in, // Watchdog timeout pulse
  input wire logic int_wake_in, // Interrupt wake pulse
  input wire logic reset_instr_in, // Reset instruction pulse
  input wire logic stack_ovf_in, // Stack overflow pulse
  input wire logic stack_unf_in, // Stack underflow pulse
  input wire logic instr_done_in, // Instruction retired pulse
  input wire logic global_interrupt_enable_in, // Interrupt enable from core
  output logic core_reset_out, // Core held in reset
  output logic pc_load_out, // Load PC pulse
  output logic [RSQ_PC_W-1:0] pc_value_out, // PC value to load
  output logic push_return_out, // Push return address pulse
  output logic timeout_flag_out, // Timeout flag
  output logic power_down_flag_out, // Power-down flag
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  initial begin
    if (CNT_W < 2 || CNT_W > 31 || POWERUP_TIMER_CYCLES < 1 || POWERUP_TIMER_CYCLES >= (32'h1 << CNT_W)) begin
      $error("rsq_reset_sequencer: POWERUP_TIMER_CYCLES does not fit CNT_W");
    end
  end

  typedef struct packed {
    logic [1:0] por_sy; // Detector synchronisers
    logic [1:0] bor_sy;
    logic [1:0] pin_sy;
    rsq_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [7:0] flags;
    logic to_f;
    logic pd_f;
    logic [3:0] cfg;
    logic vec_pend;
    logic pc_load;
    logic [RSQ_PC_W-1:0] pc;
    logic push;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsq_regs_t;

  rsq_regs_t r_q, r_d;

  logic por_s, bor_s, pin_en, pin_low, running, base;
  logic ev_por, ev_bor, ev_pin, ev_wdt, ev_wwake, ev_iwake, ev_ovf, ev_unf, ev_ri;

  // Event decode with priority power-on, brown-out, pin, then core events
  assign por_s = r_q.por_sy[1];
  assign bor_s = r_q.bor_sy[1];
  assign pin_en = r_q.cfg[RSQ_C_PIN_EN] | r_q.cfg[RSQ_C_LVP];
  assign pin_low = pin_en & ~r_q.pin_sy[1];
  assign running = (r_q.st == RSQ_ST_RUN);
  assign ev_por = por_s | prog_exit_in;
  assign ev_bor = bor_s & ~ev_por;
  assign ev_pin = running & pin_low & ~ev_por & ~bor_s;
  assign base = running & ~ev_por & ~bor_s & ~pin_low;
  assign ev_wdt = base & wdt_event_in & ~asleep_in;
  assign ev_wwake = base & wdt_event_in & asleep_in;
  assign ev_ovf = base & ~wdt_event_in & stack_ovf_in & r_q.cfg[RSQ_C_STACK_ERROR_RESET_ENABLE];
  assign ev_unf = base & ~wdt_event_in & stack_unf_in & r_q.cfg[RSQ_C_STACK_ERROR_RESET_ENABLE];
  assign ev_ri = base & ~wdt_event_in & ~ev_ovf & ~ev_unf & reset_instr_in;
  assign ev_iwake = base & ~wdt_event_in & int_wake_in & asleep_in;

  // Next-state logic for sequencer, flags and bus slave
  always_comb begin
    r_d = r_q;
    r_d.por_sy = {r_q.por_sy[0], por_det_in};
    r_d.bor_sy = {r_q.bor_sy[0], bor_det_in};
    r_d.pin_sy = {r_q.pin_sy[0], ext_reset_pin_n_in};
    r_d.pc_load = 1'b0;
    r_d.push = 1'b0;
    // Bus: accept address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_d.aw_got = 1'b1;
      r_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_d.w_got = 1'b1;
      r_d.wdata = s_axi_wdata[7:0];
      r_d.wstb = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end
    // Software write goes first so that hardware events below win
    if (r_q.aw_got && r_q.w_got) begin
      r_d.aw_got = 1'b0;
      r_d.w_got = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = RSQ_RESP_OK;
      unique case (r_q.awaddr)
        RSQ_OFS_FLAGS: if (r_q.wstb) r_d.flags = r_q.wdata & RSQ_FLAGS_WMASK;
        RSQ_OFS_CFG: if (r_q.wstb) r_d.cfg = r_q.wdata[3:0];
        RSQ_OFS_STAT: r_d.bresp = RSQ_RESP_OK;
        default: r_d.bresp = RSQ_RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_d.rvalid = 1'b1;
      r_d.rresp = RSQ_RESP_OK;
      unique case (s_axi_araddr)
        RSQ_OFS_FLAGS: r_d.rdata = {24'h000000, r_q.flags & RSQ_FLAGS_WMASK};
        RSQ_OFS_STAT: r_d.rdata = {29'h0000000, core_reset_out, r_q.to_f, r_q.pd_f};
        RSQ_OFS_CFG: r_d.rdata = {28'h0000000, r_q.cfg};
        default: begin
          r_d.rdata = 32'h00000000;
          r_d.rresp = RSQ_RESP_SLVERR;
        end
      endcase
    end
    // Sequencer
    unique case (r_q.st)
      RSQ_ST_HOLD: begin
        r_d.cnt = '0;
        if (!por_s && !bor_s) begin
          r_d.st = r_q.cfg[RSQ_C_POWERUP_TIMER_N] ? RSQ_ST_START : RSQ_ST_POWERUP_TIMER;
        end
      end
      RSQ_ST_POWERUP_TIMER: begin
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt == CNT_W'(POWERUP_TIMER_CYCLES - 1)) begin
          r_d.st = RSQ_ST_START;
        end
      end
      RSQ_ST_START: begin
        if ((!ost_required_in || ost_done_in) && !pin_low) begin
          r_d.st = RSQ_ST_RUN;
          r_d.pc_load = 1'b1;
          r_d.pc = RSQ_RESET_VEC;
        end
      end
      RSQ_ST_RUN: begin
        if (r_q.vec_pend && instr_done_in) begin
          r_d.vec_pend = 1'b0;
          r_d.push = 1'b1;
          r_d.pc_load = 1'b1;
          r_d.pc = RSQ_INT_VEC;
        end
        if (ev_pin || ev_wdt || ev_ovf || ev_unf || ev_ri) begin
          r_d.st = RSQ_ST_START;
          r_d.vec_pend = 1'b0;
        end
      end
    endcase
    // Power-on and brown-out hold the core and rewrite flags
    if (ev_por || ev_bor) begin
      r_d.st = RSQ_ST_HOLD;
      r_d.vec_pend = 1'b0;
      r_d.flags[RSQ_B_STACK_OVERFLOW_FLAG] = 1'b0;
      r_d.flags[RSQ_B_STACK_UNDERFLOW_FLAG] = 1'b0;
      r_d.flags[RSQ_B_PIN] = 1'b1;
      r_d.flags[RSQ_B_INSTR] = 1'b1;
      r_d.flags[5:4] = 2'b00;
      r_d.to_f = 1'b1;
      r_d.pd_f = 1'b1;
      if (ev_por) r_d.flags[RSQ_B_POR] = 1'b0;
      else r_d.flags[RSQ_B_BOR] = 1'b0;
    end
    // Core reset sources and wake events
    if (ev_pin) begin
      r_d.flags[RSQ_B_PIN] = 1'b0;
      if (asleep_in) begin
        r_d.to_f = 1'b1;
        r_d.pd_f = 1'b0;
      end
    end
    if (ev_wdt) r_d.to_f = 1'b0;
    if (ev_wwake) begin
      r_d.to_f = 1'b0;
      r_d.pd_f = 1'b0;
    end
    if (ev_iwake) begin
      r_d.to_f = 1'b1;
      r_d.pd_f = 1'b0;
      r_d.vec_pend = global_interrupt_enable_in;
    end
    if (ev_ovf) r_d.flags[RSQ_B_STACK_OVERFLOW_FLAG] = 1'b1;
    if (ev_unf) r_d.flags[RSQ_B_STACK_UNDERFLOW_FLAG] = 1'b1;
    if (ev_ri) r_d.flags[RSQ_B_INSTR] = 1'b0;
  end

  // State register; reset behaves as a power-on
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_q <= '0;
      r_q.pin_sy <= 2'b11;
      r_q.st <= RSQ_ST_HOLD;
      r_q.flags <= RSQ_FLAGS_RST;
      r_q.to_f <= 1'b1;
      r_q.pd_f <= 1'b1;
      r_q.cfg <= RSQ_CFG_RST;
      r_q.pc <= RSQ_RESET_VEC;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs
  assign core_reset_out = ~running;
  assign pc_load_out = r_q.pc_load;
  assign pc_value_out = r_q.pc;
  assign push_return_out = r_q.push;
  assign timeout_flag_out = r_q.to_f;
  assign power_down_flag_out = r_q.pd_f;
  assign s_axi_awready = ~r_q.aw_got & ~r_q.bvalid;
  assign s_axi_wready = ~r_q.w_got & ~r_q.bvalid;
  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_arready = ~r_q.rvalid;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_por_flags_set: assert property (ev_por |=>
    r_q.flags[7:6] == 2'b00 && r_q.flags[3:1] == 3'b110 && r_q.to_f && r_q.pd_f && core_reset_out)
    else $error("power-on flags wrong");
  a_bor_keeps_por: assert property (ev_bor |=> !r_q.flags[RSQ_B_BOR] &&
    r_q.flags[RSQ_B_POR] == $past(r_q.flags[RSQ_B_POR]) && core_reset_out)
    else $error("brown-out flags wrong");
  a_pin_flag_clr: assert property (ev_pin && asleep_in |=>
    !r_q.flags[RSQ_B_PIN] && r_q.to_f && !r_q.pd_f && core_reset_out)
    else $error("sleep pin reset flags wrong");
  a_instr_flag_clr: assert property (ev_ri |=> !r_q.flags[RSQ_B_INSTR] && core_reset_out)
    else $error("reset instruction flag wrong");
  a_stack_ovf_set: assert property (ev_ovf |=> r_q.flags[RSQ_B_STACK_OVERFLOW_FLAG] && core_reset_out)
    else $error("stack overflow flag not set");
  a_unimpl_zero: assert property (s_axi_rvalid && $rose(s_axi_rvalid) &&
    $past(s_axi_araddr) == RSQ_OFS_FLAGS |-> s_axi_rdata[5:4] == 2'b00)
    else $error("unimplemented flag bits not zero");
  a_powerup_timer_length: assert property (r_q.st == RSQ_ST_START && $past(r_q.st) == RSQ_ST_POWERUP_TIMER |->
    $past(r_q.cnt) == CNT_W'(POWERUP_TIMER_CYCLES - 1) && core_reset_out)
    else $error("power-up timer left early");
  a_pin_holds_start: assert property (r_q.st == RSQ_ST_START && pin_low && !ev_por |=>
    core_reset_out) else $error("started with pin low");
  a_release_vector: assert property ($fell(core_reset_out) |-> pc_load_out &&
    pc_value_out == RSQ_RESET_VEC) else $error("release without reset vector");
  a_int_vector: assert property (push_return_out |-> pc_load_out &&
    pc_value_out == RSQ_INT_VEC && $past(instr_done_in)) else $error("bad interrupt vector");
  a_wdt_wake: assert property (ev_wwake |=> !r_q.to_f && !r_q.pd_f && !core_reset_out)
    else $error("watchdog wake flags wrong");

  c_boot: cover property (r_q.st == RSQ_ST_POWERUP_TIMER ##[1:1000] !core_reset_out);
  c_pin_reset: cover property (ev_pin ##[1:20] $fell(core_reset_out));
  c_int_vector: cover property (ev_iwake ##[1:20] push_return_out);
  c_stack_reset: cover property (ev_ovf ##1 core_reset_out);

endmodule : rsq_reset_sequencer

`default_nettype wire

// ---- test/rsq_far_side.sv ----
// Far-side model: supply detectors, external reset pin and oscillator start-up timer.
// Assumes the bench commands it on the device clock; the released pin is pulled up.
`timescale 1ns/1ps
`default_nettype none
module rsq_far_side #(
  parameter int OST_CYC = 30 // Oscillator start-up length in cycles
) (
  input wire logic clk_in, // Device clock
  input wire logic rst_in, // Reset, active high
  input wire logic por_cmd_in, // Hold supply below power-on level
  input wire logic bor_cmd_in, // Hold supply below brown-out level
  input wire logic pin_low_cmd_in, // Press the reset pin
  output logic por_det_out, // Power-on detector
  output logic bor_det_out, // Brown-out detector
  output logic pin_n_out, // Reset pin level
  output logic ost_done_out // Oscillator start-up finished
);
  int cnt_q;
  // Detectors follow the supply; a released pin goes to its pull-up level
  assign por_det_out = por_cmd_in;
  assign bor_det_out = bor_cmd_in;
  assign pin_n_out = ~pin_low_cmd_in;
  // Oscillator timer restarts on supply events and ignores the pin
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) cnt_q <= 0;
    else if (por_cmd_in || bor_cmd_in) cnt_q <= 0;
    else if (cnt_q < OST_CYC) cnt_q <= cnt_q + 1;
  end
  assign ost_done_out = (cnt_q >= OST_CYC);
endmodule : rsq_far_side
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the reset sequencer, its flags and its register slave.
// Assumes the far-side model drives detectors, pin and oscillator timer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; exp_v = 34'(e); if (34'(a) !== exp_v) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, exp_v); end end
module testbench;
  import rsq_pkg::*;
  logic clk, rst, por, bor, pin_low, ostreq, ost_done, asleep, global_interrupt_enable, por_det, bor_det, pin_n;
  logic [6:0] ev;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic core_reset, pc_load, push_ret, to_flag, pd_flag;
  logic [15:0] pc_val;
  logic [33:0] exp_v;
  logic [33:0] rq[$];
  logic [33:0] wq[$];
  logic [16:0] pq[$];
  int n_errors = 0;
  int checked = 0;
  int n_cyc;
  localparam logic [7:0] FL = RSQ_OFS_FLAGS;
  localparam logic [7:0] ST = RSQ_OFS_STAT;
  localparam logic [7:0] CF = RSQ_OFS_CFG;
  localparam logic [7:0] UNMAPPED = 8'h0C;
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  rsq_far_side u_far (.clk_in(clk), .rst_in(rst), .por_cmd_in(por), .bor_cmd_in(bor),
    .pin_low_cmd_in(pin_low), .por_det_out(por_det), .bor_det_out(bor_det),
    .pin_n_out(pin_n), .ost_done_out(ost_done));
  rsq_reset_sequencer #(.POWERUP_TIMER_CYCLES(20)) u_dut (.sys_clk_in(clk), .rst_in(rst),
    .por_det_in(por_det), .bor_det_in(bor_det), .ext_reset_pin_n_in(pin_n),
    .prog_exit_in(ev[0]), .ost_required_in(ostreq), .ost_done_in(ost_done),
    .asleep_in(asleep), .wdt_event_in(ev[1]), .int_wake_in(ev[2]), .reset_instr_in(ev[3]),
    .stack_ovf_in(ev[4]), .stack_unf_in(ev[5]), .instr_done_in(ev[6]),
    .global_interrupt_enable_in(global_interrupt_enable), .core_reset_out(core_reset), .pc_load_out(pc_load),
    .pc_value_out(pc_val), .push_return_out(push_ret), .timeout_flag_out(to_flag),
    .power_down_flag_out(pd_flag), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // Watchers: each answer is compared against the oldest note
  always @(posedge clk) begin
    if (rvalid && rready) `CHK({rresp, rdata}, rq.size() > 0 ? rq.pop_front() : 34'bx)
    if (bvalid && bready) `CHK(bresp, wq.size() > 0 ? wq.pop_front() : 34'bx)
    if (pc_load) `CHK({push_ret, pc_val}, pq.size() > 0 ? pq.pop_front() : 17'bx)
  end
  task report_and_stop;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task tmo;
    n_errors++;
    $display("Error at %0t: wait ran out", $time);
    report_and_stop;
  endtask : tmo
  task wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    wq.push_back(34'(a == UNMAPPED ? RSQ_RESP_SLVERR : RSQ_RESP_OK));
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 50) tmo();
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    rq.push_back({(a == UNMAPPED ? RSQ_RESP_SLVERR : RSQ_RESP_OK), d});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (k == 50) tmo();
  endtask : rd
  task pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask : pulse
  // Waits for the core reset level with a cycle limit, noting the count
  task waitc(input logic v, input int lim);
    n_cyc = 0;
    while (core_reset !== v) begin
      @(posedge clk);
      n_cyc++;
      if (n_cyc > lim) tmo();
    end
  endtask : waitc
  task boot(input logic [16:0] e);
    pq.push_back(e);
  endtask : boot
  task done(input string s);
    $display("test %s finished", s);
  endtask : done
  // Main sequence
  initial begin
    rst = 1'b1; por = 0; bor = 0; pin_low = 0; ostreq = 1; asleep = 0; global_interrupt_enable = 0; ev = '0;
    awaddr = '0; araddr = '0; wdata = '0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0;
    rnd = $urandom(34429);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    boot(17'h00000); waitc(1'b0, 300);
    rd(ST, 32'h3); rd(FL, 32'h0C); done("power-on");
    rnd = $urandom; wr(FL, rnd); rd(FL, rnd & 32'hCF);
    rd(UNMAPPED, 32'h0); wr(UNMAPPED, 32'hFF); wr(ST, 32'h0); rd(ST, 32'h3);
    wr(FL, 32'h0F); rd(FL, 32'h0F); done("registers");
    boot(17'h00000); pin_low <= 1; repeat (5) @(posedge clk); pin_low <= 0;
    repeat (3) @(posedge clk); waitc(1'b0, 100); rd(FL, 32'h07); rd(ST, 32'h3);
    boot(17'h00000); pulse(3); repeat (3) @(posedge clk); waitc(1'b0, 100);
    rd(FL, 32'h03); done("pin and instruction");
    pulse(4); repeat (5) @(posedge clk); rd(FL, 32'h03); wr(CF, 32'h0A);
    boot(17'h00000); pulse(4); repeat (3) @(posedge clk); waitc(1'b0, 100); rd(FL, 32'h83);
    boot(17'h00000); pulse(5); repeat (3) @(posedge clk); waitc(1'b0, 100); rd(FL, 32'hC3);
    wr(FL, 32'h0F); rd(FL, 32'h0F); done("stack");
    boot(17'h00000); pulse(1); repeat (3) @(posedge clk); waitc(1'b0, 100); rd(ST, 32'h1);
    `CHK({to_flag, pd_flag}, 2'b01)
    asleep <= 1; global_interrupt_enable <= 1; pulse(2); asleep <= 0; rd(ST, 32'h2);
    `CHK({to_flag, pd_flag}, 2'b10)
    boot({1'b1, RSQ_INT_VEC}); pulse(6); repeat (3) @(posedge clk);
    asleep <= 1; pulse(1); asleep <= 0; rd(ST, 32'h0); done("wake");
    asleep <= 1; boot(17'h00000); pin_low <= 1; repeat (5) @(posedge clk); pin_low <= 0;
    asleep <= 0; repeat (3) @(posedge clk); waitc(1'b0, 100); rd(ST, 32'h2); rd(FL, 32'h07);
    wr(CF, 32'h00); pin_low <= 1; repeat (6) @(posedge clk);
    `CHK(core_reset, 1'b0)
    pin_low <= 0; wr(CF, 32'h04); boot(17'h00000); pin_low <= 1; repeat (6) @(posedge clk);
    `CHK(core_reset, 1'b1)
    pin_low <= 0; repeat (3) @(posedge clk); waitc(1'b0, 100); done("pin enable");
    ostreq <= 0; wr(FL, 32'h0F); wr(CF, 32'h02); boot(17'h00000);
    bor <= 1; repeat (4) @(posedge clk); bor <= 0; waitc(1'b0, 60);
    `CHK(n_cyc inside {[20:30]}, 1'b1)
    rd(FL, 32'h0E); rd(ST, 32'h3); wr(CF, 32'h03); boot(17'h00000);
    bor <= 1; repeat (4) @(posedge clk); bor <= 0; waitc(1'b0, 60);
    `CHK(n_cyc inside {[1:8]}, 1'b1)
    wr(FL, 32'h0F); wr(CF, 32'h02); boot(17'h00000); pulse(0); repeat (3) @(posedge clk);
    waitc(1'b0, 100); rd(FL, 32'h0D); done("brown-out and exit");
    ostreq <= 1; boot(17'h00000); por <= 1; pin_low <= 1; repeat (4) @(posedge clk);
    por <= 0; repeat (70) @(posedge clk);
    `CHK(core_reset, 1'b1)
    pin_low <= 0; waitc(1'b0, 6); rd(FL, 32'h0D); done("start-up");
    `CHK(pq.size(), 0)
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
